//--- fpb_pkg.sv
`default_nettype none
package fpb_pkg;
    // opcodes
    localparam logic [7:0] OP_ID = 8'h77;
    localparam logic [7:0] OP_XFER_B1 = 8'h53;
    localparam logic [7:0] OP_XFER_B2 = 8'h55;
    localparam logic [7:0] OP_CMP_B1 = 8'h60;
    localparam logic [7:0] OP_CMP_B2 = 8'h61;
    localparam logic [7:0] OP_RW_B1 = 8'h58;
    localparam logic [7:0] OP_RW_B2 = 8'h59;
    localparam logic [7:0] OP_STATUS = 8'hd7;
    // sizes
    localparam int unsigned ID_BYTES = 128;
    localparam int unsigned ADDR_BYTES = 3;
    localparam int unsigned CMD_BITS_ADDR = 32;
    localparam int unsigned CMD_BITS_OP = 8;
    localparam int unsigned MODEL_PAGES = 4;
    localparam int unsigned MODEL_BYTES = 16;
    localparam logic [3:0] DENSITY = 4'hb;
    localparam int unsigned ST_RDY = 7;
    localparam int unsigned ST_COMP = 6;
    // address layout: page index low bit
    localparam int unsigned PG_LSB_512 = 9;
    localparam int unsigned PG_LSB_528 = 10;
    localparam int unsigned PG_BITS = 12;
    // timing
    localparam int unsigned CLK_MHZ = 100;
    localparam int unsigned PAGE_LOAD_DURATION_NS = 200000;
    localparam int unsigned CHECK_DURATION_NS = 200000;
    localparam int unsigned REFRESH_DURATION_NS = 25000000;
    localparam int unsigned PAGE_LOAD_CYC = PAGE_LOAD_DURATION_NS * CLK_MHZ / 1000;
    localparam int unsigned CHECK_CYC = CHECK_DURATION_NS * CLK_MHZ / 1000;
    localparam int unsigned REFRESH_CYC = REFRESH_DURATION_NS * CLK_MHZ / 1000;
    localparam int unsigned SCK_PERIOD_NS = 80;
    localparam int unsigned SCK_HALF_CYC = SCK_PERIOD_NS * CLK_MHZ / 2000;
    localparam int unsigned FIFO_W = 8;
    localparam int unsigned FIFO_D = 8;
    // reset values
    localparam logic [2:0] SYNC_CS_RST = 3'h7;
    localparam logic [2:0] SYNC_LOW_RST = 3'h0;
endpackage : fpb_pkg
`default_nettype wire

//--- fpb_if.sv
`timescale 1ns/1ps
`default_nettype none
interface fpb_if;
    logic cs_n;
    logic sck;
    logic si;
    logic so;
    logic so_oe;
    modport dev (input cs_n, input sck, input si, output so, output so_oe);
    modport host (output cs_n, output sck, output si, input so, input so_oe);
endinterface : fpb_if
`default_nettype wire

//--- fpb_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module fpb_fifo #(
    parameter int unsigned W = 8,
    parameter int unsigned D = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int unsigned AW = $clog2(D);
    logic [W-1:0] mem_q [D];
    logic [AW-1:0] wp_q;
    logic [AW-1:0] rp_q;
    logic [AW:0] cnt_q;
    logic do_w;
    logic do_r;

    assign in_ready = cnt_q != (AW+1)'(D);
    assign out_valid = cnt_q != '0;
    assign out_data = mem_q[rp_q];
    assign do_w = in_valid && in_ready;
    assign do_r = out_valid && out_ready;

    always_ff @(posedge clk) begin
        if (do_w) begin
            mem_q[wp_q] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end else begin
            if (do_w) begin
                wp_q <= (wp_q == AW'(D - 1)) ? '0 : wp_q + 1'b1;
            end
            if (do_r) begin
                rp_q <= (rp_q == AW'(D - 1)) ? '0 : rp_q + 1'b1;
            end
            if (do_w && !do_r) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (do_r && !do_w) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule : fpb_fifo
`default_nettype wire

//--- fpb_dev.sv
`timescale 1ns/1ps
`default_nettype none
// Contract
// - fixed unique 128-byte identification register
// - 77h plus three dummies streams id
// - bytes past 127 are undefined
// - chip select high ends read, floats output
// - 53h/55h load page into buffer
// - 528 format: 2 dummy, 12 page, 10 dummy
// - 512 format: 3 dummy, page A20-A9, 9
// - host keeps select low while shifting
// - copy starts on select rise, busy
// - 60h/61h compare page with buffer
// - compare on select rise, busy meanwhile
// - compare result in status bit 6
// - 58h/59h auto rewrite through buffer
// - rewrite loads then reprograms page, busy
// - host refreshes pages within 50,000 erase operations; fpb_host keeps no count and issues no refresh
// - data after rewrite address means modify
// - D7h streams two status bytes repeatedly
// - status bit 7 low while busy
// - compare flag one on any mismatch
module fpb_dev #(
    parameter int unsigned LOAD_CYC = fpb_pkg::PAGE_LOAD_CYC,
    parameter int unsigned CHECK_CYC = fpb_pkg::CHECK_CYC,
    parameter int unsigned REFRESH_CYC = fpb_pkg::REFRESH_CYC,
    parameter logic [7:0] ID_SEED = 8'h5a // arbitrary value
) (
    input wire logic REF_CLK,
    input wire logic SYS_RST,
    input wire logic PAGE_512,
    output logic BUSY,
    output logic COMP_FLAG,
    fpb_if.dev LINK
);
    localparam int unsigned MB = fpb_pkg::MODEL_BYTES;
    localparam int unsigned MP = fpb_pkg::MODEL_PAGES;
    localparam int unsigned BW = $clog2(MB);
    localparam int unsigned PW = $clog2(MP);

    typedef enum logic [2:0] {
        L_OP = 3'b000, L_SHIFT = 3'b001, L_DATA = 3'b010,
        L_ID_OUT = 3'b011, L_ST_OUT = 3'b100, L_IGNORE = 3'b101
    } fpb_link_t;
    typedef enum logic [1:0] {
        O_IDLE = 2'b00, O_LOAD = 2'b01, O_CHECK = 2'b10, O_PROG = 2'b11
    } fpb_op_t;

    logic [2:0] cs_s_q, sck_s_q;
    logic [1:0] si_s_q;
    logic cs_hi, sck_rise, sck_fall, cs_rise;
    fpb_link_t link_q;
    fpb_op_t op_q;
    logic [2:0] bit_q, obit_q;
    logic [7:0] rx_q, rx_d, cmd_q, tx_q, oidx_q;
    logic [1:0] abyte_q;
    logic [23:0] addr_q;
    logic [BW-1:0] dcnt_q;
    logic [MB-1:0] mask_q;
    logic armed_q, rmw_q, then_prog_q, comp_q, p512_q, sel, byte_done, op_sel_q;
    logic [31:0] tmr_q;
    logic [7:0] buf_q [2][MB];
    logic [7:0] mem_q [MP][MB];
    logic [PW-1:0] pg, op_pg_q;
    logic [7:0] st1, st2, obyte;
    logic start, load_now, prog_now, mismatch;

    function automatic logic [7:0] id_byte(input logic [7:0] idx);
        logic [15:0] p;
        p = {8'h00, idx} * 16'h0025;
        return p[7:0] ^ ID_SEED;
    endfunction : id_byte

    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            cs_s_q <= fpb_pkg::SYNC_CS_RST;
            sck_s_q <= fpb_pkg::SYNC_LOW_RST;
            si_s_q <= 2'h0;
        end else begin
            cs_s_q <= {cs_s_q[1:0], LINK.cs_n};
            sck_s_q <= {sck_s_q[1:0], LINK.sck};
            si_s_q <= {si_s_q[0], LINK.si};
        end
    end
    assign cs_hi = cs_s_q[1];
    assign cs_rise = cs_s_q[1] && !cs_s_q[2];
    assign sck_rise = !cs_hi && sck_s_q[1] && !sck_s_q[2];
    assign sck_fall = !cs_hi && !sck_s_q[1] && sck_s_q[2];
    assign rx_d = {rx_q[6:0], si_s_q[1]};
    assign byte_done = sck_rise && (bit_q == 3'h7) &&
        (link_q == L_OP || link_q == L_SHIFT || link_q == L_DATA);
    assign sel = cmd_q == fpb_pkg::OP_XFER_B2 || cmd_q == fpb_pkg::OP_CMP_B2 ||
        cmd_q == fpb_pkg::OP_RW_B2;
    // page index taken from its format field
    assign pg = p512_q ? addr_q[fpb_pkg::PG_LSB_512 +: PW] :
        addr_q[fpb_pkg::PG_LSB_528 +: PW];

    always_ff @(posedge REF_CLK) begin
        if (SYS_RST || cs_hi) begin
            link_q <= L_OP;
            bit_q <= 3'h0;
            rx_q <= 8'h00;
            abyte_q <= 2'h0;
        end else begin
            if (sck_rise) begin
                bit_q <= bit_q + 3'h1;
                rx_q <= rx_d;
            end
            if (byte_done) begin
                unique case (link_q)
                    L_OP: begin
                        unique case (rx_d)
                            fpb_pkg::OP_STATUS: link_q <= L_ST_OUT;
                            fpb_pkg::OP_ID, fpb_pkg::OP_XFER_B1, fpb_pkg::OP_XFER_B2,
                            fpb_pkg::OP_CMP_B1, fpb_pkg::OP_CMP_B2, fpb_pkg::OP_RW_B1,
                            fpb_pkg::OP_RW_B2: link_q <= L_SHIFT;
                            default: link_q <= L_IGNORE;
                        endcase
                    end
                    L_SHIFT: begin
                        abyte_q <= abyte_q + 2'h1;
                        if (abyte_q == 2'(fpb_pkg::ADDR_BYTES - 1)) begin
                            if (cmd_q == fpb_pkg::OP_ID) begin
                                link_q <= L_ID_OUT;
                            end else if (cmd_q == fpb_pkg::OP_RW_B1 ||
                                         cmd_q == fpb_pkg::OP_RW_B2) begin
                                link_q <= L_DATA;
                            end else begin
                                link_q <= L_IGNORE;
                            end
                        end
                    end
                    default: link_q <= link_q;
                endcase
            end
        end
    end

    // command, address and modify data capture
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            cmd_q <= 8'h00;
            addr_q <= 24'h000000;
            armed_q <= 1'b0;
            rmw_q <= 1'b0;
            dcnt_q <= '0;
            mask_q <= '0;
            p512_q <= 1'b0;
        end else begin
            if (cs_rise) begin
                armed_q <= 1'b0;
            end
            if (byte_done && link_q == L_OP) begin
                cmd_q <= rx_d;
                armed_q <= 1'b0;
                rmw_q <= 1'b0;
                dcnt_q <= '0;
                mask_q <= '0;
                p512_q <= PAGE_512;
            end
            if (byte_done && link_q == L_SHIFT) begin
                addr_q <= {addr_q[15:0], rx_d};
                armed_q <= abyte_q == 2'(fpb_pkg::ADDR_BYTES - 1) && cmd_q != fpb_pkg::OP_ID;
            end
            if (byte_done && link_q == L_DATA) begin
                rmw_q <= 1'b1;
                mask_q[dcnt_q] <= 1'b1;
                dcnt_q <= dcnt_q + 1'b1;
            end
        end
    end

    // output shifting on falling edges
    assign st1 = {!BUSY, comp_q, fpb_pkg::DENSITY, 1'b0, p512_q};
    assign st2 = {!BUSY, 7'h00};
    always_comb begin
        obyte = 8'hff;
        if (link_q == L_ST_OUT) begin
            obyte = oidx_q[0] ? st2 : st1;
        end else if (oidx_q < 8'(fpb_pkg::ID_BYTES)) begin
            obyte = id_byte(oidx_q);
        end
    end
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST || cs_hi) begin
            LINK.so <= 1'b0;
            tx_q <= 8'h00;
            obit_q <= 3'h0;
            oidx_q <= 8'h00;
        end else if (sck_fall && (link_q == L_ID_OUT || link_q == L_ST_OUT)) begin
            obit_q <= obit_q + 3'h1;
            if (obit_q == 3'h0) begin
                LINK.so <= obyte[7];
                tx_q <= {obyte[6:0], 1'b0};
            end else begin
                LINK.so <= tx_q[7];
                tx_q <= {tx_q[6:0], 1'b0};
            end
            if (obit_q == 3'h7 && oidx_q != 8'hff) begin
                oidx_q <= oidx_q + 8'h01;
            end
        end
    end
    assign LINK.so_oe = !cs_hi && (link_q == L_ID_OUT || link_q == L_ST_OUT);

    // internal operation engine
    assign start = cs_rise && armed_q && op_q == O_IDLE;
    assign load_now = start && cmd_q != fpb_pkg::OP_CMP_B1 && cmd_q != fpb_pkg::OP_CMP_B2;
    assign prog_now = op_q == O_PROG && tmr_q == 32'h0;
    always_comb begin
        mismatch = 1'b0;
        for (int b = 0; b < MB; b++) begin
            mismatch = mismatch | (mem_q[op_pg_q][b] != buf_q[op_sel_q][b]);
        end
    end
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            op_q <= O_IDLE;
            tmr_q <= 32'h0;
            comp_q <= 1'b0;
            then_prog_q <= 1'b0;
            op_sel_q <= 1'b0;
            op_pg_q <= '0;
        end else if (start) begin
            then_prog_q <= cmd_q == fpb_pkg::OP_RW_B1 || cmd_q == fpb_pkg::OP_RW_B2;
            op_sel_q <= sel;
            op_pg_q <= pg;
            if (load_now) begin
                op_q <= O_LOAD;
                tmr_q <= 32'(LOAD_CYC - 1);
            end else begin
                op_q <= O_CHECK;
                tmr_q <= 32'(CHECK_CYC - 1);
            end
        end else if (op_q != O_IDLE) begin
            if (tmr_q != 32'h0) begin
                tmr_q <= tmr_q - 32'h1;
            end else if (op_q == O_LOAD && then_prog_q) begin
                op_q <= O_PROG;
                tmr_q <= 32'(REFRESH_CYC - 1);
            end else begin
                if (op_q == O_CHECK) begin
                    comp_q <= mismatch;
                end
                op_q <= O_IDLE;
            end
        end
    end
    assign BUSY = op_q != O_IDLE;
    assign COMP_FLAG = comp_q;

    always_ff @(posedge REF_CLK) begin
        for (int b = 0; b < MB; b++) begin
            if (load_now && !(rmw_q && mask_q[b])) begin
                buf_q[sel][b] <= mem_q[pg][b];
            end else if (byte_done && link_q == L_DATA && dcnt_q == BW'(b)) begin
                buf_q[sel][b] <= rx_d;
            end
        end
    end
    always_ff @(posedge REF_CLK) begin
        for (int p = 0; p < MP; p++) begin
            for (int b = 0; b < MB; b++) begin
                if (SYS_RST) begin
                    mem_q[p][b] <= 8'(p * 16 + b + 3);
                end else if (prog_now && op_pg_q == PW'(p)) begin
                    mem_q[p][b] <= buf_q[op_sel_q][b];
                end
            end
        end
    end
endmodule : fpb_dev
`default_nettype wire

//--- fpb_host.sv
`timescale 1ns/1ps
`default_nettype none
module fpb_host (
    input wire logic REF_CLK,
    input wire logic SYS_RST,
    input wire logic CMD_VALID,
    output logic CMD_READY,
    input wire logic [7:0] CMD_OP,
    input wire logic [11:0] CMD_PAGE,
    input wire logic [7:0] CMD_LEN,
    input wire logic PAGE_512,
    output logic RX_VALID,
    input wire logic RX_READY,
    output logic [7:0] RX_DATA,
    output logic DONE,
    fpb_if.host LINK
);
    localparam logic [2:0] HALF = 3'(fpb_pkg::SCK_HALF_CYC - 1);
    typedef enum logic [1:0] {
        H_IDLE = 2'b00, H_LOW = 2'b01, H_HIGH = 2'b10, H_END = 2'b11
    } fpb_hst_t;

    fpb_hst_t st_q;
    logic [1:0] so_s_q;
    logic [2:0] ph_q, gap_q;
    logic [11:0] bit_q, tot_q, txb_q, rd_idx;
    logic [31:0] tx_q;
    logic [7:0] rx_q, rxd_q;
    logic push_q, push_ready, stall;
    logic [23:0] addr;

    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            so_s_q <= 2'h0;
        end else begin
            so_s_q <= {so_s_q[0], LINK.so};
        end
    end

    // page index placed by configured page format
    assign addr = PAGE_512 ? {3'h0, CMD_PAGE, 9'h000} :
        {2'h0, CMD_PAGE, 10'h000};
    assign CMD_READY = st_q == H_IDLE && gap_q == 3'h0;
    assign rd_idx = bit_q - txb_q;
    assign stall = bit_q >= txb_q && rd_idx[2:0] == 3'h0 && !push_ready;

    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            st_q <= H_IDLE;
            LINK.cs_n <= 1'b1;
            LINK.sck <= 1'b0;
            LINK.si <= 1'b0;
            ph_q <= 3'h0;
            gap_q <= 3'h0;
            bit_q <= 12'h000;
            tot_q <= 12'h000;
            txb_q <= 12'h000;
            tx_q <= 32'h0;
            rx_q <= 8'h00;
            rxd_q <= 8'h00;
            push_q <= 1'b0;
            DONE <= 1'b0;
        end else begin
            push_q <= 1'b0;
            DONE <= 1'b0;
            unique case (st_q)
                H_IDLE: begin
                    if (gap_q != 3'h0) begin
                        gap_q <= gap_q - 3'h1;
                    end else if (CMD_VALID) begin
                        tx_q <= {CMD_OP, addr};
                        txb_q <= (CMD_OP == fpb_pkg::OP_STATUS) ?
                            12'(fpb_pkg::CMD_BITS_OP) : 12'(fpb_pkg::CMD_BITS_ADDR);
                        tot_q <= ((CMD_OP == fpb_pkg::OP_STATUS) ?
                            12'(fpb_pkg::CMD_BITS_OP) : 12'(fpb_pkg::CMD_BITS_ADDR)) +
                            {1'b0, CMD_LEN, 3'h0};
                        LINK.cs_n <= 1'b0;
                        LINK.si <= CMD_OP[7];
                        bit_q <= 12'h000;
                        ph_q <= 3'h0;
                        st_q <= H_LOW;
                    end
                end
                H_LOW: begin
                    if (ph_q != HALF) begin
                        ph_q <= ph_q + 3'h1;
                    end else if (!stall) begin
                        LINK.sck <= 1'b1;
                        ph_q <= 3'h0;
                        st_q <= H_HIGH;
                    end
                end
                H_HIGH: begin
                    if (ph_q != HALF) begin
                        ph_q <= ph_q + 3'h1;
                    end else begin
                        ph_q <= 3'h0;
                        LINK.sck <= 1'b0;
                        tx_q <= {tx_q[30:0], 1'b0};
                        LINK.si <= tx_q[30];
                        bit_q <= bit_q + 12'h001;
                        if (bit_q >= txb_q) begin
                            rx_q <= {rx_q[6:0], so_s_q[1]};
                            if (rd_idx[2:0] == 3'h7) begin
                                rxd_q <= {rx_q[6:0], so_s_q[1]};
                                push_q <= 1'b1;
                            end
                        end
                        st_q <= (bit_q == tot_q - 12'h001) ? H_END : H_LOW;
                    end
                end
                H_END: begin
                    if (ph_q != HALF) begin
                        ph_q <= ph_q + 3'h1;
                    end else begin
                        LINK.cs_n <= 1'b1;
                        LINK.si <= 1'b0;
                        gap_q <= HALF;
                        DONE <= 1'b1;
                        st_q <= H_IDLE;
                    end
                end
            endcase
        end
    end

    fpb_fifo #(
        .W(fpb_pkg::FIFO_W),
        .D(fpb_pkg::FIFO_D)
    ) u_rx_fifo (
        .clk(REF_CLK),
        .rst(SYS_RST),
        .in_valid(push_q),
        .in_ready(push_ready),
        .in_data(rxd_q),
        .out_valid(RX_VALID),
        .out_ready(RX_READY),
        .out_data(RX_DATA)
    );
endmodule : fpb_host
`default_nettype wire

//--- fpb_link_properties.sv
`timescale 1ns/1ps
`default_nettype none
module fpb_link_properties (
    input wire logic REF_CLK,
    input wire logic SYS_RST,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic si,
    input wire logic so,
    input wire logic so_oe,
    input wire logic BUSY,
    input wire logic COMP_FLAG,
    input wire logic DONE
);
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (SYS_RST);
    a_oe_off_idle: assert property (cs_n [*5] |-> !so_oe)
        else $error("so_oe high while deselected");
    a_oe_rise_sel: assert property ($rose(so_oe) |-> !cs_n)
        else $error("so_oe rose while deselected");
    a_sck_in_frame: assert property (sck |-> !cs_n)
        else $error("sck high outside a frame");
    a_si_low_phase: assert property ($changed(si) |-> !sck)
        else $error("si moved while sck high");
    a_so_hold_high: assert property ($rose(sck) && so_oe |=> $stable(so) [*2])
        else $error("so moved while sck high");
    a_busy_after_cs: assert property ($rose(BUSY) |-> cs_n)
        else $error("busy rose inside a frame");
    a_busy_bounded: assert property ($rose(BUSY) |=> BUSY [*8] ##[1:1000] !BUSY)
        else $error("busy too short or too long");
    a_comp_at_end: assert property ($changed(COMP_FLAG) |-> !BUSY && ($past(BUSY) || $past(BUSY, 2)))
        else $error("compare flag moved outside busy end");
    a_done_cs_rise: assert property (DONE |-> $rose(cs_n))
        else $error("done without select rise");
    c_id_out: cover property ($rose(so_oe));
    c_busy_end: cover property ($fell(BUSY));
    c_comp_set: cover property ($rose(COMP_FLAG));
endmodule : fpb_link_properties
`default_nettype wire

//--- flash_page_buffer_ops_tb.sv
`timescale 1ns/1ps
`default_nettype none
module flash_page_buffer_ops_tb;
    localparam logic [7:0] ID_VAL = 8'h3c; // arbitrary value
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic cmd_valid = 1'b0;
    logic [7:0] cmd_op = 8'h00;
    logic [11:0] cmd_page = 12'h000;
    logic [7:0] cmd_len = 8'h00;
    logic page_512 = 1'b0;
    logic rx_ready = 1'b0;
    logic cmd_ready, rx_valid, done, busy, comp_flag;
    logic [7:0] rx_data;
    logic [7:0] rxq[$];
    logic hold_rx = 1'b0;
    logic exp_comp = 1'b0;
    logic sck_d = 1'b0;
    logic [31:0] sh = 32'h0;
    logic [7:0] op_seen = 8'h00;
    logic [11:0] p, q;
    int cnt = 0;
    int failures = 0;
    int n_checks = 0;
    int unsigned seed;
    fpb_if fpb_if_inst ();
    fpb_dev #(.LOAD_CYC(300), .CHECK_CYC(300), .REFRESH_CYC(500), .ID_SEED(ID_VAL)) fpb_dev_inst (
        .REF_CLK(ref_clk), .SYS_RST(sys_rst), .PAGE_512(page_512), .BUSY(busy),
        .COMP_FLAG(comp_flag), .LINK(fpb_if_inst.dev));
    fpb_host fpb_host_inst (
        .REF_CLK(ref_clk), .SYS_RST(sys_rst), .CMD_VALID(cmd_valid), .CMD_READY(cmd_ready),
        .CMD_OP(cmd_op), .CMD_PAGE(cmd_page), .CMD_LEN(cmd_len), .PAGE_512(page_512),
        .RX_VALID(rx_valid), .RX_READY(rx_ready), .RX_DATA(rx_data), .DONE(done),
        .LINK(fpb_if_inst.host));
    fpb_link_properties fpb_link_properties_inst (
        .REF_CLK(ref_clk), .SYS_RST(sys_rst), .cs_n(fpb_if_inst.cs_n), .sck(fpb_if_inst.sck),
        .si(fpb_if_inst.si), .so(fpb_if_inst.so), .so_oe(fpb_if_inst.so_oe), .BUSY(busy),
        .COMP_FLAG(comp_flag), .DONE(done));
    initial begin
        forever #5 ref_clk = ~ref_clk;
    end
    // random drain with stalls
    always @(posedge ref_clk) begin
        rx_ready <= !hold_rx && ($urandom % 4 != 0);
        if (rx_valid && rx_ready) rxq.push_back(rx_data);
    end
    // capture the first 32 bits of each frame off the wire
    always @(posedge ref_clk) begin
        sck_d <= fpb_if_inst.sck;
        if (fpb_if_inst.cs_n) cnt <= 0;
        else if (fpb_if_inst.sck && !sck_d && cnt < 32) begin
            sh <= {sh[30:0], fpb_if_inst.si};
            cnt <= cnt + 1;
            if (cnt == 7) op_seen <= {sh[6:0], fpb_if_inst.si};
        end
    end
    task automatic end_of_test();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : end_of_test
    task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("BAD %s exp %h got %h", what, exp, got);
        end
    endtask : chk8
    task automatic chk1(input string what, input logic exp, input logic got);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("BAD %s exp %b got %b", what, exp, got);
        end
    endtask : chk1
    function automatic logic [7:0] id_exp(input int i);
        return 8'((i * 37) % 256) ^ ID_VAL;
    endfunction : id_exp
    task automatic run(input logic [7:0] op, input logic [11:0] pg, input logic [7:0] len);
        logic [23:0] a;
        int t;
        rxq.delete();
        for (t = 0; t < 100 && cmd_ready !== 1'b1; t++) @(negedge ref_clk);
        chk1("command ready", 1'b1, cmd_ready);
        @(posedge ref_clk);
        a = page_512 ? {3'h0, pg, 9'h000} : {2'h0, pg, 10'h000};
        cmd_valid <= 1'b1;
        cmd_op <= op;
        cmd_page <= pg;
        cmd_len <= len;
        @(posedge ref_clk);
        cmd_valid <= 1'b0;
        for (t = 0; t < 30000 && done !== 1'b1; t++) @(negedge ref_clk);
        chk1("done pulse", 1'b1, done);
        chk8("opcode on wire", op, op_seen);
        if (op != fpb_pkg::OP_STATUS && op != fpb_pkg::OP_ID)
            for (int k = 0; k < 3; k++) chk8("address byte", a[8*k+:8], sh[8*k+:8]);
        for (t = 0; t < 3000 && rxq.size() < len; t++) @(negedge ref_clk);
        chk8("rx count", len, 8'(rxq.size()));
    endtask : run
    task automatic status(input logic rdy);
        run(fpb_pkg::OP_STATUS, 12'h000, 8'd3);
        chk1("ready bit byte 1", rdy, rxq[0][fpb_pkg::ST_RDY]);
        chk1("ready bit byte 2", rdy, rxq[1][7]);
        if (rdy) begin
            chk8("status 1", {1'b1, exp_comp, fpb_pkg::DENSITY, 1'b0, page_512}, rxq[0]);
            chk8("status 2", 8'h80, rxq[1]);
            chk8("status repeat", {1'b1, exp_comp, fpb_pkg::DENSITY, 1'b0, page_512}, rxq[2]);
        end
    endtask : status
    task automatic xop(input logic [7:0] op, input logic [11:0] pg, input logic c);
        int t;
        run(op, pg, 8'd0);
        repeat (6) @(negedge ref_clk);
        chk1("busy after select rise", 1'b1, busy);
        status(1'b0);
        for (t = 0; t < 2000 && busy !== 1'b0; t++) @(negedge ref_clk);
        chk1("busy ends", 1'b0, busy);
        if (op == fpb_pkg::OP_CMP_B1 || op == fpb_pkg::OP_CMP_B2) exp_comp = c;
        chk1("compare flag", exp_comp, comp_flag);
        status(1'b1);
    endtask : xop
    initial begin
        repeat (90000) @(posedge ref_clk);
        failures++;
        end_of_test();
    end
    initial begin
        seed = $urandom(75470);
        repeat (3) @(posedge ref_clk);
        sys_rst <= 1'b0;
        hold_rx <= 1'b1;
        fork
            run(fpb_pkg::OP_ID, 12'h000, 8'd130);
            begin
                repeat (2000) @(negedge ref_clk);
                chk1("frame held on full fifo", 1'b0, fpb_if_inst.cs_n);
                chk1("sck parked on full fifo", 1'b0, fpb_if_inst.sck);
                hold_rx <= 1'b0;
            end
        join
        for (int i = 0; i < 128; i++) chk8("id byte", id_exp(i), rxq[i]);
        for (int f = 0; f < 2; f++) begin
            p = 12'($urandom);
            q = p ^ 12'h001;
            @(posedge ref_clk);
            page_512 <= f[0];
            xop(fpb_pkg::OP_XFER_B1, p, 1'b0);
            xop(fpb_pkg::OP_XFER_B2, q, 1'b0);
            xop(fpb_pkg::OP_CMP_B1, p, 1'b0);
            xop(fpb_pkg::OP_CMP_B2, p, 1'b1);
            xop(fpb_pkg::OP_RW_B2, p, 1'b0);
            xop(fpb_pkg::OP_CMP_B2, p, 1'b0);
            xop(fpb_pkg::OP_CMP_B1, q, 1'b1);
            xop(fpb_pkg::OP_RW_B1, q, 1'b0);
            xop(fpb_pkg::OP_CMP_B1, q, 1'b0);
            xop(fpb_pkg::OP_CMP_B2, q, 1'b1);
        end
        run(fpb_pkg::OP_ID, 12'h000, 8'd4);
        for (int i = 0; i < 4; i++) chk8("id byte again", id_exp(i), rxq[i]);
        end_of_test();
    end
endmodule : flash_page_buffer_ops_tb
`default_nettype wire
